// ==== design/strap_div_config.sv ====
// Contract
// - four divider groups; groups 1-3 divide 1 to 8, group four 1 to 1045.
// - group four digital delay is inoperative when its divide value is one.
// - mode pin low: pin0 outs 0-3, pin1 outs 4-11, pin2 gives 8/512/16.
// - mode pin high: pin0 outs 0-7, pin1 outs 8-11, pin2 gives 4/512/16.
// - serial latch strobe pin acts as divider strap two in strap mode.
// - test pin acts as drive type strap zero in strap mode.
// - bank A sync pin is type strap one in strap mode, sync otherwise.
// - three-state mode pin picks serial programming or strap configuration.
`timescale 1ns/1ps
`include "strap_div_consts.svh"
module strap_div_config (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// three-level pins as upper and lower comparator outputs
	input wire logic i_mode_above,
	input wire logic i_mode_below,
	input wire logic i_div_strap_zero_above,
	input wire logic i_div_strap_zero_below,
	input wire logic i_div_strap_one_above,
	input wire logic i_div_strap_one_below,
	input wire logic i_div_strap_two_above,
	input wire logic i_div_strap_two_below,
	input wire logic i_drive_type_strap_zero_above,
	input wire logic i_drive_type_strap_zero_below,
	input wire logic i_drive_type_strap_one_above,
	input wire logic i_drive_type_strap_one_below,
	input wire logic i_drive_type_strap_two_above,
	input wire logic i_drive_type_strap_two_below,
	// register port
	input wire logic [1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// applied configuration
	output strap_div_pkg::div_cfg_t o_div,
	output strap_div_pkg::type_cfg_t o_type,
	output logic o_strap_mode,
	output logic o_delay_active,
	output logic o_serial_latch_strobe,
	output logic o_bank_a_sync_request
);
	localparam int NPIN = 7;
	logic [NPIN-1:0] above_w;
	logic [NPIN-1:0] below_w;
	logic [NPIN-1:0] high_sync_w;
	strap_div_pkg::level_t lvl_w [NPIN];

	assign above_w = {i_drive_type_strap_two_above, i_drive_type_strap_one_above,
		i_drive_type_strap_zero_above, i_div_strap_two_above, i_div_strap_one_above,
		i_div_strap_zero_above, i_mode_above};
	assign below_w = {i_drive_type_strap_two_below, i_drive_type_strap_one_below,
		i_drive_type_strap_zero_below, i_div_strap_two_below, i_div_strap_one_below,
		i_div_strap_zero_below, i_mode_below};

	// one resolver per three-level pin
	for (genvar g = 0; g < NPIN; g++) begin : g_sense
		tri_level_sense u_sense (
			.i_clk(i_clk),
			.i_nrst(i_nrst),
			.i_above(above_w[g]),
			.i_below(below_w[g]),
			.o_level(lvl_w[g]),
			.o_high_sync(high_sync_w[g])
		);
	end

	// mode decode: middle level selects serial programming
	strap_div_pkg::mode_t mode_w;
	assign mode_w = (lvl_w[0] == strap_div_pkg::LVL_LOW) ? strap_div_pkg::MODE_STRAP_LO :
		(lvl_w[0] == strap_div_pkg::LVL_HIGH) ? strap_div_pkg::MODE_STRAP_HI :
		strap_div_pkg::MODE_SERIAL;

	// software registers
	logic [8:0] small_code_r;
	logic [10:0] large_div_r;
	logic delay_en_r;
	logic large_ok_w;
	logic wr_small_w;
	logic wr_large_w;
	logic wr_delay_w;
	assign large_ok_w = (i_wdata[10:0] >= `LARGE_DIV_MIN) &&
		(i_wdata[10:0] <= `LARGE_DIV_MAX);
	// out-of-range large divide writes are dropped, old value kept
	assign wr_small_w = i_wr && (i_addr == `REG_SMALL_DIV);
	assign wr_large_w = i_wr && (i_addr == `REG_LARGE_DIV) && large_ok_w;
	assign wr_delay_w = i_wr && (i_addr == `REG_DELAY_CTL);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			small_code_r <= `SMALL_CODE_RESET;
			large_div_r <= `LARGE_DIV_RESET;
			delay_en_r <= 1'b0;
		end else begin
			if (wr_small_w) begin
				small_code_r <= i_wdata[8:0];
			end
			if (wr_large_w) begin
				large_div_r <= i_wdata[10:0];
			end
			if (wr_delay_w) begin
				delay_en_r <= i_wdata[`DELAY_EN_BIT];
			end
		end
	end

	// strap ratio lookups
	function automatic logic [3:0] small_ratio(input strap_div_pkg::level_t l);
		case (l)
			strap_div_pkg::LVL_LOW: small_ratio = `DIV_SMALL_LOW;
			strap_div_pkg::LVL_MID: small_ratio = `DIV_SMALL_MID;
			strap_div_pkg::LVL_HIGH: small_ratio = `DIV_SMALL_HIGH;
			default: small_ratio = `DIV_SMALL_LOW;
		endcase
	endfunction : small_ratio

	function automatic logic [10:0] large_ratio(input strap_div_pkg::level_t l,
		input logic mode_hi);
		case (l)
			strap_div_pkg::LVL_LOW: large_ratio = mode_hi ? `DIV_LARGE_LOW_MHI :
				`DIV_LARGE_LOW_MLO;
			strap_div_pkg::LVL_MID: large_ratio = `DIV_LARGE_MID;
			strap_div_pkg::LVL_HIGH: large_ratio = `DIV_LARGE_HIGH;
			default: large_ratio = `DIV_LARGE_LOW_MLO;
		endcase
	endfunction : large_ratio

	logic [3:0] pin0_ratio_w;
	logic [3:0] pin1_ratio_w;
	logic [10:0] pin2_ratio_w;
	assign pin0_ratio_w = small_ratio(lvl_w[1]);
	assign pin1_ratio_w = small_ratio(lvl_w[2]);
	assign pin2_ratio_w = large_ratio(lvl_w[3], mode_w == strap_div_pkg::MODE_STRAP_HI);

	strap_div_pkg::div_cfg_t ser_div_w;
	strap_div_pkg::div_cfg_t strap_lo_div_w;
	strap_div_pkg::div_cfg_t strap_hi_div_w;
	strap_div_pkg::type_cfg_t strap_lo_type_w;
	strap_div_pkg::type_cfg_t strap_hi_type_w;
	strap_div_pkg::div_cfg_t div_nxt;
	strap_div_pkg::type_cfg_t type_nxt;

	// serial mode: small codes hold divide minus one, so only 1 to 8 fit
	assign ser_div_w = '{
		g4: large_div_r,
		g3: {1'b0, small_code_r[`G3_CODE_LSB +: `SMALL_CODE_W]} + 4'h1,
		g2: {1'b0, small_code_r[`G2_CODE_LSB +: `SMALL_CODE_W]} + 4'h1,
		g1: {1'b0, small_code_r[`G1_CODE_LSB +: `SMALL_CODE_W]} + 4'h1
	};

	// mode pin low: pin0 feeds group one, pin1 groups two and three
	assign strap_lo_div_w = '{
		g4: pin2_ratio_w,
		g3: pin1_ratio_w,
		g2: pin1_ratio_w,
		g1: pin0_ratio_w
	};
	assign strap_lo_type_w = '{
		g4: lvl_w[6],
		g3: lvl_w[6],
		g2: lvl_w[5],
		g1: lvl_w[4]
	};

	// mode pin high: pin0 feeds groups one and two, pin1 group three
	assign strap_hi_div_w = '{
		g4: pin2_ratio_w,
		g3: pin1_ratio_w,
		g2: pin0_ratio_w,
		g1: pin0_ratio_w
	};
	assign strap_hi_type_w = '{
		g4: lvl_w[6],
		g3: lvl_w[5],
		g2: lvl_w[4],
		g1: lvl_w[4]
	};

	// serial mode leaves the drive-type groups at their low setting
	always_comb begin
		div_nxt = ser_div_w;
		type_nxt = '{default: strap_div_pkg::LVL_LOW};
		case (mode_w)
			strap_div_pkg::MODE_STRAP_LO: begin
				div_nxt = strap_lo_div_w;
				type_nxt = strap_lo_type_w;
			end
			strap_div_pkg::MODE_STRAP_HI: begin
				div_nxt = strap_hi_div_w;
				type_nxt = strap_hi_type_w;
			end
			strap_div_pkg::MODE_SERIAL: begin
				div_nxt = ser_div_w;
			end
			default: begin
				div_nxt = ser_div_w;
			end
		endcase
	end

	logic strap_w;
	logic delay_nxt;
	assign strap_w = (mode_w != strap_div_pkg::MODE_SERIAL);
	// delay only when requested and the large divider is not bypassed
	assign delay_nxt = delay_en_r && (div_nxt.g4 != `LARGE_DIV_MIN);

	logic [15:0] status_w;
	logic [15:0] rdata_nxt;
	assign status_w = {12'h000, o_delay_active, mode_w};
	assign rdata_nxt = (i_addr == `REG_SMALL_DIV) ? {7'h00, small_code_r} :
		(i_addr == `REG_LARGE_DIV) ? {5'h00, large_div_r} :
		(i_addr == `REG_DELAY_CTL) ? {15'h0000, delay_en_r} :
		status_w;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_div <= '{g4: `LARGE_DIV_RESET, g3: 4'h1, g2: 4'h1, g1: 4'h1};
			o_type <= '{default: strap_div_pkg::LVL_LOW};
			o_strap_mode <= 1'b0;
			o_delay_active <= 1'b0;
			o_serial_latch_strobe <= 1'b0;
			o_bank_a_sync_request <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_div <= div_nxt;
			o_type <= type_nxt;
			o_strap_mode <= strap_w;
			o_delay_active <= delay_nxt;
			o_serial_latch_strobe <= !strap_w && high_sync_w[3];
			o_bank_a_sync_request <= !strap_w && high_sync_w[5];
			o_rdata <= i_rd ? rdata_nxt : 16'h0000;
		end
	end
endmodule : strap_div_config

// ==== design/strap_div_consts.svh ====
`ifndef STRAP_DIV_CONSTS_SVH
`define STRAP_DIV_CONSTS_SVH

// register indexes on the plain port
`define REG_SMALL_DIV 2'h0
`define REG_LARGE_DIV 2'h1
`define REG_DELAY_CTL 2'h2
`define REG_STATUS 2'h3

// small divider field: three 3-bit codes holding divide minus one
`define SMALL_CODE_W 3
`define G1_CODE_LSB 0
`define G2_CODE_LSB 3
`define G3_CODE_LSB 6
`define SMALL_CODE_RESET 9'h000

// large divider limits and reset
`define LARGE_DIV_MIN 11'h001
`define LARGE_DIV_MAX 11'h415
`define LARGE_DIV_RESET 11'h001
`define DELAY_EN_BIT 0

// strap-mode divide ratios
`define DIV_SMALL_LOW 4'h1
`define DIV_SMALL_MID 4'h4
`define DIV_SMALL_HIGH 4'h2
`define DIV_LARGE_LOW_MLO 11'h008
`define DIV_LARGE_LOW_MHI 11'h004
`define DIV_LARGE_MID 11'h200
`define DIV_LARGE_HIGH 11'h010

`endif

// ==== design/strap_div_pkg.sv ====
package strap_div_pkg;

	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_MID = 2'h1,
		LVL_HIGH = 2'h2
	} level_t;

	typedef enum logic [2:0] {
		MODE_SERIAL = 3'h1,
		MODE_STRAP_LO = 3'h2,
		MODE_STRAP_HI = 3'h4
	} mode_t;

	typedef struct packed {
		logic [10:0] g4;
		logic [3:0] g3;
		logic [3:0] g2;
		logic [3:0] g1;
	} div_cfg_t;

	typedef struct packed {
		level_t g4;
		level_t g3;
		level_t g2;
		level_t g1;
	} type_cfg_t;

endpackage : strap_div_pkg

// ==== design/tri_level_sense.sv ====
`timescale 1ns/1ps
module tri_level_sense (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// pin comparators
	input wire logic i_above,
	input wire logic i_below,
	// resolved level
	output strap_div_pkg::level_t o_level,
	output logic o_high_sync
);
	logic [1:0] above_s_r;
	logic [1:0] below_s_r;
	strap_div_pkg::level_t level_nxt;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			above_s_r <= 2'h0;
			below_s_r <= 2'h0;
		end else begin
			above_s_r <= {above_s_r[0], i_above};
			below_s_r <= {below_s_r[0], i_below};
		end
	end

	// neither comparator tripped means the pin floats at mid level
	assign level_nxt = above_s_r[1] ? strap_div_pkg::LVL_HIGH :
		below_s_r[1] ? strap_div_pkg::LVL_LOW : strap_div_pkg::LVL_MID;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			// cleared synchronisers read as mid, so reset must agree
			o_level <= strap_div_pkg::LVL_MID;
			o_high_sync <= 1'b0;
		end else begin
			o_level <= level_nxt;
			o_high_sync <= above_s_r[1];
		end
	end
endmodule : tri_level_sense

// ==== testbench/strap_div_config_assertions.sv ====
`timescale 1ns/1ps
module strap_div_config_assertions (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_mode_above,
	input wire logic i_mode_below,
	input wire logic [1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire strap_div_pkg::div_cfg_t o_div,
	input wire strap_div_pkg::type_cfg_t o_type,
	input wire logic o_strap_mode,
	input wire logic o_delay_active,
	input wire logic o_serial_latch_strobe,
	input wire logic o_bank_a_sync_request
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	sequence s_g4_wr;
		i_wr && i_addr == 2'h1 && i_wdata[10:0] inside {[11'h001:11'h415]} && !o_strap_mode;
	endsequence
	sequence s_applied;
		##2 o_div.g4 == $past(i_wdata[10:0], 2);
	endsequence
	AST_G4_WR: assert property (s_g4_wr |-> s_applied)
		else $error("g4 write not applied");
	AST_RANGE: assert property (o_div.g1 inside {[4'h1:4'h8]} && o_div.g2 inside {[4'h1:4'h8]}
		&& o_div.g3 inside {[4'h1:4'h8]} && o_div.g4 inside {[11'h001:11'h415]})
		else $error("divide out of range");
	AST_DLY_OFF: assert property (o_div.g4 == 11'h001 |-> !o_delay_active)
		else $error("delay active at divide one");
	AST_STRAP_G4: assert property (o_strap_mode [*2] |->
		o_div.g4 inside {11'h008, 11'h004, 11'h200, 11'h010}) else $error("bad strap g4");
	AST_STRAP_SMALL: assert property (o_strap_mode [*2] |-> o_div.g1 inside {4'h1, 4'h4, 4'h2})
		else $error("bad strap g1");
	AST_LOW_PAIR: assert property ((i_mode_below && !i_mode_above) [*6] |-> o_div.g2 == o_div.g3)
		else $error("g2 g3 differ");
	AST_HIGH_PAIR: assert property (i_mode_above [*6] |->
		o_div.g1 == o_div.g2 && o_type.g1 == o_type.g2) else $error("g1 g2 differ");
	AST_MODE: assert property ((i_mode_above || i_mode_below) [*6] |-> o_strap_mode)
		else $error("strap mode missing");
	AST_LATCH_OFF: assert property (o_strap_mode [*2] |-> !o_serial_latch_strobe)
		else $error("latch strobe in strap mode");
	AST_SYNC_OFF: assert property (o_strap_mode [*2] |-> !o_bank_a_sync_request)
		else $error("sync in strap mode");
	AST_TYPE_SER: assert property ((!o_strap_mode) [*2] |-> o_type == 8'h00)
		else $error("type set in serial mode");
endmodule : strap_div_config_assertions
bind strap_div_config strap_div_config_assertions u_chk (.*);

// ==== testbench/strap_pins.sv ====
`timescale 1ns/1ps
module strap_pins (
	// wanted level per pin: mode, div 0..2, type 0..2
	input wire strap_div_pkg::level_t i_lvl [7],
	// comparator pair per pin
	output wire logic [6:0] o_above,
	output wire logic [6:0] o_below
);
	for (genvar k = 0; k < 7; k++) begin : g_pin
		assign o_above[k] = i_lvl[k] == strap_div_pkg::LVL_HIGH;
		assign o_below[k] = i_lvl[k] == strap_div_pkg::LVL_LOW;
	end
endmodule : strap_pins

// ==== testbench/tb_strap_div_config.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module tb_strap_div_config;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	strap_div_pkg::div_cfg_t o_div;
	strap_div_pkg::type_cfg_t o_type;
	logic o_strap_mode, o_delay_active, o_serial_latch_strobe, o_bank_a_sync_request;
	strap_div_pkg::level_t lvl [7] = '{default: strap_div_pkg::LVL_MID};
	logic [6:0] ab, be;
	int error_cnt = 0;
	int n_tests = 0;
	always #12.5 i_clk = ~i_clk;
	strap_pins u_pins (.i_lvl(lvl), .o_above(ab), .o_below(be));
	strap_div_config u_dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_mode_above(ab[0]), .i_mode_below(be[0]),
		.i_div_strap_zero_above(ab[1]), .i_div_strap_zero_below(be[1]),
		.i_div_strap_one_above(ab[2]), .i_div_strap_one_below(be[2]),
		.i_div_strap_two_above(ab[3]), .i_div_strap_two_below(be[3]),
		.i_drive_type_strap_zero_above(ab[4]), .i_drive_type_strap_zero_below(be[4]),
		.i_drive_type_strap_one_above(ab[5]), .i_drive_type_strap_one_below(be[5]),
		.i_drive_type_strap_two_above(ab[6]), .i_drive_type_strap_two_below(be[6]),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_div(o_div), .o_type(o_type), .o_strap_mode(o_strap_mode),
		.o_delay_active(o_delay_active), .o_serial_latch_strobe(o_serial_latch_strobe),
		.o_bank_a_sync_request(o_bank_a_sync_request));
	function automatic logic [3:0] sm(input int l);
		return l == 0 ? 4'h1 : l == 1 ? 4'h4 : 4'h2;
	endfunction : sm
	function automatic logic [10:0] lg(input int m, input int l);
		return l == 1 ? 11'h200 : l == 2 ? 11'h010 : m ? 11'h004 : 11'h008;
	endfunction : lg
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic t_regs;
		logic [15:0] d;
		wr(2'h1, 16'h0415);
		tick(1);
		`CHK(o_div.g4, 11'h415)
		wr(2'h1, 16'h0000);
		wr(2'h1, 16'h0416);
		wr(2'h0, 16'h01ff);
		tick(1);
		`CHK(o_div, {11'h415, 4'h8, 4'h8, 4'h8})
		wr(2'h2, 16'h0001);
		tick(1);
		`CHK(o_delay_active, 1'b1)
		wr(2'h1, 16'h0001);
		tick(1);
		`CHK(o_delay_active, 1'b0)
		wr(2'h3, 16'h00ff);
		rd(2'h3, d);
		`CHK(d, 16'h0001)
		rd(2'h0, d);
		`CHK(d, 16'h01ff)
		tick(1);
		`CHK(o_rdata, 16'h0000)
		rd(2'h1, d);
		`CHK(d, 16'h0001)
		rd(2'h2, d);
		`CHK(d, 16'h0001)
		@(posedge i_clk);
		lvl[3] <= strap_div_pkg::LVL_HIGH;
		lvl[5] <= strap_div_pkg::LVL_HIGH;
		tick(6);
		`CHK({o_serial_latch_strobe, o_bank_a_sync_request}, 2'h3)
		`CHK(o_type, 8'h00)
	endtask : t_regs
	task automatic t_strap;
		logic [1:0] a, b, c;
		logic [15:0] d;
		for (int m = 0; m < 2; m++) begin
			for (int l = 0; l < 3; l++) begin
				a = 2'(l);
				b = 2'((l + 1) % 3);
				c = 2'((l + 2) % 3);
				@(posedge i_clk);
				lvl[0] <= m ? strap_div_pkg::LVL_HIGH : strap_div_pkg::LVL_LOW;
				lvl[1] <= strap_div_pkg::level_t'(a);
				lvl[2] <= strap_div_pkg::level_t'(b);
				lvl[3] <= strap_div_pkg::level_t'(a);
				lvl[4] <= strap_div_pkg::level_t'(a);
				lvl[5] <= strap_div_pkg::level_t'(b);
				lvl[6] <= strap_div_pkg::level_t'(c);
				tick(6);
				`CHK(o_strap_mode, 1'b1)
				`CHK(o_div, {lg(m, a), sm(m ? b : b), sm(m ? a : b), sm(a)})
				`CHK(o_type, m ? {c, b, a, a} : {c, c, b, a})
				`CHK({o_serial_latch_strobe, o_bank_a_sync_request}, 2'h0)
				`CHK(o_delay_active, 1'b1)
				rd(2'h3, d);
				`CHK(d, (m ? 16'h000c : 16'h000a))
			end
		end
		@(posedge i_clk);
		lvl[0] <= strap_div_pkg::LVL_MID;
		tick(6);
		`CHK(o_div, {11'h001, 4'h8, 4'h8, 4'h8})
	endtask : t_strap
	task automatic t_reset;
		logic [15:0] d;
		@(posedge i_clk);
		i_nrst <= 1'b0;
		tick(2);
		`CHK(o_div, {11'h001, 4'h1, 4'h1, 4'h1})
		@(posedge i_clk);
		i_nrst <= 1'b1;
		rd(2'h0, d);
		`CHK(d, 16'h0000)
		rd(2'h2, d);
		`CHK(d, 16'h0000)
		`CHK(o_strap_mode, 1'b0)
	endtask : t_reset
	task automatic wrap_up;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		tick(1);
		`CHK(o_div, {11'h001, 4'h1, 4'h1, 4'h1})
		t_regs();
		t_strap();
		t_reset();
		wrap_up();
	end
	initial begin
		#100us;
		error_cnt++;
		wrap_up();
	end
endmodule : tb_strap_div_config
